// >>> tlc_translation_caches.sv
// Translation lookaside buffer and upper-level paging caches.
// Assumes a page walker that reports each finished level and performs
// accessed-bit writes on request, and an AHB-Lite master for control.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module tlc_translation_caches #(
	parameter bit EN_LEAF = 1'b1,
	parameter bit EN_DIR = 1'b1,
	parameter bit EN_THIRD = 1'b1,
	parameter bit EN_TOP = 1'b1,
	parameter int LEAF_N = 16,
	parameter int DIR_N = 8,
	parameter int THIRD_N = 4,
	parameter int TOP_N = 4
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Lookup request from the translation pipeline.
	input wire logic lookup_valid,
	input wire logic [tlc_pkg::LIN_W-1:0] lookup_addr,
	// Lookup answer, one cycle after the request.
	output logic lookup_done,
	output tlc_pkg::tlc_level_t lookup_level,
	output logic [tlc_pkg::FRAME_W-1:0] lookup_phys,
	output logic lookup_wr,
	output logic lookup_us,
	output logic no_exec_bit,
	output logic cache_disable_bit,
	output logic write_through_bit,
	output logic lookup_dirty,
	output logic [tlc_pkg::MTYPE_W-1:0] lookup_mtype,
	output logic lookup_global,
	// Fill from the page walker, one completed level per pulse.
	input wire logic fill_valid,
	input wire tlc_pkg::tlc_level_t fill_level,
	input wire logic [tlc_pkg::LIN_W-1:0] fill_addr,
	input wire logic [tlc_pkg::FRAME_W-1:0] fill_phys,
	input wire logic fill_wr,
	input wire logic fill_us,
	input wire logic fill_nx,
	input wire logic fill_cd,
	input wire logic fill_wt,
	input wire logic fill_present,
	input wire logic fill_rsvd_clear,
	input wire logic fill_accessed,
	input wire logic large_mapping_bit,
	input wire logic fill_dirty,
	input wire logic [tlc_pkg::MTYPE_W-1:0] fill_mtype,
	input wire logic fill_global,
	// Request to the walker to set accessed bits before a retry.
	output logic accessed_set_req,
	output tlc_pkg::tlc_level_t accessed_set_level
);
	import tlc_pkg::*;

	// Refuse entry counts that the wrapping round-robin pointers cannot serve.
	if (LEAF_N < 2 || DIR_N < 2 || THIRD_N < 2 || TOP_N < 2
		|| (LEAF_N & (LEAF_N - 1)) != 0 || (DIR_N & (DIR_N - 1)) != 0
		|| (THIRD_N & (THIRD_N - 1)) != 0
		|| (TOP_N & (TOP_N - 1)) != 0) begin : g_bad_size
		$error("Each cache needs a power-of-two count of two or more.");
	end

	localparam int LW = $clog2(LEAF_N);
	localparam int DW = $clog2(DIR_N);
	localparam int HW = $clog2(THIRD_N);
	localparam int TW = $clog2(TOP_N);

	// Key of a directory-cache entry in the current mode.
	function automatic logic [DIR_TAG_W-1:0] dir_key(
		input logic [LIN_W-1:0] a, input tlc_mode_t m);
		case (m)
			TLC_MODE_32: dir_key = {17'h0_0000, a[31:22]};
			TLC_MODE_EXT: dir_key = {16'h0000, a[31:21]};
			default: dir_key = a[47:21];
		endcase
	endfunction

	// Leaf match for small or large stored pages.
	function automatic logic leaf_match(input logic [VPN_W-1:0] tag,
		input logic lg, input logic [LIN_W-1:0] a, input tlc_mode_t m);
		if (!lg)
			leaf_match = (tag == a[47:12]);
		else if (m == TLC_MODE_32)
			leaf_match = (tag[35:10] == a[47:22]);
		else
			leaf_match = (tag[35:9] == a[47:21]);
	endfunction

	// Frame of a hit; large pages take low bits from the linear address.
	function automatic logic [FRAME_W-1:0] leaf_frame(
		input logic [FRAME_W-1:0] f, input logic lg,
		input logic [LIN_W-1:0] a, input tlc_mode_t m);
		if (!lg)
			leaf_frame = f;
		else if (m == TLC_MODE_32)
			leaf_frame = {f[39:10], a[21:12]};
		else
			leaf_frame = {f[39:9], a[20:12]};
	endfunction

	// Control registers.
	logic [3:0] ctrl;
	logic [31:0] inv_lo;
	logic [31:0] hit_count;
	logic [31:0] miss_count;
	wire tlc_mode_t mode = tlc_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
	wire logic nxe = ctrl[CTRL_NXE_BIT];
	wire logic gpe = ctrl[CTRL_GPE_BIT];

	// Leaf entries.
	logic [LEAF_N-1:0] l_v;
	logic [VPN_W-1:0] l_tag [LEAF_N];
	logic [FRAME_W-1:0] l_frame [LEAF_N];
	logic [LEAF_N-1:0] l_lg, l_wr, l_us, l_nx, l_d, l_g;
	logic [MTYPE_W-1:0] l_mt [LEAF_N];
	logic [LW-1:0] l_ptr;
	// Upper entries share one layout: tag, address, rights, cache bits.
	logic [DIR_N-1:0] d_v, d_wr, d_us, d_nx, d_cd, d_wt;
	logic [DIR_TAG_W-1:0] d_tag [DIR_N];
	logic [FRAME_W-1:0] d_adr [DIR_N];
	logic [DW-1:0] d_ptr;
	logic [THIRD_N-1:0] h_v, h_wr, h_us, h_nx, h_cd, h_wt;
	logic [THIRD_TAG_W-1:0] h_tag [THIRD_N];
	logic [FRAME_W-1:0] h_adr [THIRD_N];
	logic [HW-1:0] h_ptr;
	logic [TOP_N-1:0] t_v, t_wr, t_us, t_nx, t_cd, t_wt;
	logic [TOP_TAG_W-1:0] t_tag [TOP_N];
	logic [FRAME_W-1:0] t_adr [TOP_N];
	logic [TW-1:0] t_ptr;

	// AHB address phase captured for the data phase.
	logic wr_pend;
	logic [7:0] wr_addr;
	wire logic addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
	wire logic rd_take = addr_ok & ~hwrite;
	wire logic wr_take = addr_ok & hwrite;
	wire logic wr_ctrl = wr_pend & (wr_addr == REG_CTRL);
	wire logic wr_flush = wr_pend & (wr_addr == REG_FLUSH)
		& hwdata[FLUSH_GO_BIT];
	wire logic inv_go = wr_pend & (wr_addr == REG_INV_HI);
	wire logic [LIN_W-1:0] inv_addr = {hwdata[15:0], inv_lo};
	// Changing the global enable drops everything, global pages included.
	wire logic gpe_flip = wr_ctrl & (hwdata[CTRL_GPE_BIT] != gpe);
	wire logic flush_all = gpe_flip | (wr_flush & hwdata[FLUSH_ALL_BIT]);
	wire logic flush_ng = wr_flush & ~hwdata[FLUSH_ALL_BIT];
	wire logic drop_upper = flush_all | flush_ng | inv_go;

	// Register read decode; unmapped offsets read as zero.
	logic [31:0] rd_val;
	always_comb begin
		case (haddr[7:0])
			REG_CTRL: rd_val = {28'h000_0000, ctrl};
			REG_INV_LO: rd_val = inv_lo;
			REG_HITS: rd_val = hit_count;
			REG_MISSES: rd_val = miss_count;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Lookup search; lowest matching index wins when sizes overlap.
	logic l_hit, d_hit, h_hit, t_hit;
	logic [LW-1:0] l_idx;
	logic [DW-1:0] d_idx;
	logic [HW-1:0] h_idx;
	logic [TW-1:0] t_idx;
	always_comb begin
		l_hit = 1'b0;
		l_idx = '0;
		for (int i = LEAF_N - 1; i >= 0; i--) begin
			if (EN_LEAF && l_v[i]
				&& leaf_match(l_tag[i], l_lg[i], lookup_addr, mode)) begin
				l_hit = 1'b1;
				l_idx = LW'(i);
			end
		end
		d_hit = 1'b0;
		d_idx = '0;
		for (int i = DIR_N - 1; i >= 0; i--) begin
			if (EN_DIR && d_v[i] && d_tag[i] == dir_key(lookup_addr, mode)) begin
				d_hit = 1'b1;
				d_idx = DW'(i);
			end
		end
		h_hit = 1'b0;
		h_idx = '0;
		for (int i = THIRD_N - 1; i >= 0; i--) begin
			if (EN_THIRD && mode == TLC_MODE_FOUR && h_v[i]
				&& h_tag[i] == lookup_addr[47:30]) begin
				h_hit = 1'b1;
				h_idx = HW'(i);
			end
		end
		t_hit = 1'b0;
		t_idx = '0;
		for (int i = TOP_N - 1; i >= 0; i--) begin
			if (EN_TOP && mode == TLC_MODE_FOUR && t_v[i]
				&& t_tag[i] == lookup_addr[47:39]) begin
				t_hit = 1'b1;
				t_idx = TW'(i);
			end
		end
	end

	// Fill acceptance per level.
	wire logic fill_clean = fill_present & fill_rsvd_clear;
	wire logic fill_ok = fill_valid & fill_clean & fill_accessed;
	wire logic fill_leaf = EN_LEAF & fill_ok & (fill_level == TLC_LVL_LEAF);
	wire logic fill_dir = EN_DIR & fill_ok & ~large_mapping_bit
		& (fill_level == TLC_LVL_DIR);
	wire logic fill_third = EN_THIRD & fill_ok & (mode == TLC_MODE_FOUR)
		& (fill_level == TLC_LVL_THIRD);
	wire logic fill_top = EN_TOP & fill_ok & (mode == TLC_MODE_FOUR)
		& (fill_level == TLC_LVL_TOP);
	wire logic [VPN_W-1:0] fill_vpn = fill_addr[47:12];

	// Bus slave and control registers.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			ctrl <= CTRL_RESET;
			inv_lo <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_take)
				hrdata <= rd_val;
			wr_pend <= wr_take;
			if (wr_take)
				wr_addr <= haddr[7:0];
			if (wr_ctrl)
				ctrl <= hwdata[3:0];
			if (wr_pend && wr_addr == REG_INV_LO)
				inv_lo <= hwdata;
		end
	end

	// Lookup answer, registered; deepest cached level reported on a miss.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lookup_done <= 1'b0;
			lookup_level <= TLC_LVL_NONE;
			lookup_phys <= '0;
			{lookup_wr, lookup_us, no_exec_bit} <= 3'h0;
			{cache_disable_bit, write_through_bit} <= 2'h0;
			lookup_dirty <= 1'b0;
			lookup_mtype <= '0;
			lookup_global <= 1'b0;
			hit_count <= 32'h0000_0000;
			miss_count <= 32'h0000_0000;
		end else begin
			lookup_done <= lookup_valid;
			if (lookup_valid && l_hit) begin
				lookup_level <= TLC_LVL_LEAF;
				lookup_phys <= leaf_frame(l_frame[l_idx], l_lg[l_idx],
					lookup_addr, mode);
				lookup_wr <= l_wr[l_idx];
				lookup_us <= l_us[l_idx];
				no_exec_bit <= l_nx[l_idx] & nxe;
				{cache_disable_bit, write_through_bit} <= 2'h0;
				lookup_dirty <= l_d[l_idx];
				lookup_mtype <= l_mt[l_idx];
				lookup_global <= l_g[l_idx];
			end else if (lookup_valid) begin
				lookup_dirty <= 1'b0;
				lookup_mtype <= '0;
				lookup_global <= 1'b0;
				if (d_hit) begin
					lookup_level <= TLC_LVL_DIR;
					lookup_phys <= d_adr[d_idx];
					{lookup_wr, lookup_us, no_exec_bit} <=
						{d_wr[d_idx], d_us[d_idx], d_nx[d_idx]};
					{cache_disable_bit, write_through_bit} <=
						{d_cd[d_idx], d_wt[d_idx]};
				end else if (h_hit) begin
					lookup_level <= TLC_LVL_THIRD;
					lookup_phys <= h_adr[h_idx];
					{lookup_wr, lookup_us, no_exec_bit} <=
						{h_wr[h_idx], h_us[h_idx], h_nx[h_idx]};
					{cache_disable_bit, write_through_bit} <=
						{h_cd[h_idx], h_wt[h_idx]};
				end else if (t_hit) begin
					lookup_level <= TLC_LVL_TOP;
					lookup_phys <= t_adr[t_idx];
					{lookup_wr, lookup_us, no_exec_bit} <=
						{t_wr[t_idx], t_us[t_idx], t_nx[t_idx]};
					{cache_disable_bit, write_through_bit} <=
						{t_cd[t_idx], t_wt[t_idx]};
				end else begin
					lookup_level <= TLC_LVL_NONE;
					lookup_phys <= '0;
					{lookup_wr, lookup_us, no_exec_bit} <= 3'h0;
					{cache_disable_bit, write_through_bit} <= 2'h0;
				end
			end
			if (lookup_valid && l_hit)
				hit_count <= hit_count + 32'h0000_0001;
			if (lookup_valid && !l_hit)
				miss_count <= miss_count + 32'h0000_0001;
		end
	end

	// Accessed-bit request; the walker sets them and fills again.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			accessed_set_req <= 1'b0;
			accessed_set_level <= TLC_LVL_NONE;
		end else begin
			accessed_set_req <= fill_valid & fill_clean & ~fill_accessed;
			accessed_set_level <= fill_level;
		end
	end

	// Leaf cache valid bits: clears first, a same-cycle fill wins.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			l_v <= '0;
			l_ptr <= '0;
		end else begin
			for (int i = 0; i < LEAF_N; i++) begin
				if (flush_all || (flush_ng && !l_g[i])
					|| (inv_go && leaf_match(l_tag[i], l_lg[i], inv_addr, mode)))
					l_v[i] <= 1'b0;
			end
			if (fill_leaf) begin
				l_v[l_ptr] <= 1'b1;
				l_ptr <= l_ptr + 1'b1;
			end
		end
	end

	// Leaf cache payload.
	always_ff @(posedge ref_clk) begin
		if (fill_leaf) begin
			l_tag[l_ptr] <= fill_vpn;
			l_frame[l_ptr] <= fill_phys;
			l_lg[l_ptr] <= large_mapping_bit;
			l_wr[l_ptr] <= fill_wr;
			l_us[l_ptr] <= fill_us;
			l_nx[l_ptr] <= fill_nx & nxe;
			l_d[l_ptr] <= fill_dirty;
			l_mt[l_ptr] <= fill_mtype;
			l_g[l_ptr] <= gpe & fill_global;
		end
	end

	// Directory cache; entries carry no global mark.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			d_v <= '0;
			d_ptr <= '0;
		end else begin
			if (drop_upper)
				d_v <= '0;
			if (fill_dir) begin
				d_v[d_ptr] <= 1'b1;
				d_ptr <= d_ptr + 1'b1;
			end
		end
		if (fill_dir) begin
			d_tag[d_ptr] <= dir_key(fill_addr, mode);
			d_adr[d_ptr] <= fill_phys;
			{d_wr[d_ptr], d_us[d_ptr], d_nx[d_ptr]} <=
				{fill_wr, fill_us, fill_nx & nxe};
			{d_cd[d_ptr], d_wt[d_ptr]} <= {fill_cd, fill_wt};
		end
	end

	// Third-level cache.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			h_v <= '0;
			h_ptr <= '0;
		end else begin
			if (drop_upper)
				h_v <= '0;
			if (fill_third) begin
				h_v[h_ptr] <= 1'b1;
				h_ptr <= h_ptr + 1'b1;
			end
		end
		if (fill_third) begin
			h_tag[h_ptr] <= fill_addr[47:30];
			h_adr[h_ptr] <= fill_phys;
			{h_wr[h_ptr], h_us[h_ptr], h_nx[h_ptr]} <=
				{fill_wr, fill_us, fill_nx & nxe};
			{h_cd[h_ptr], h_wt[h_ptr]} <= {fill_cd, fill_wt};
		end
	end

	// Top-level cache.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			t_v <= '0;
			t_ptr <= '0;
		end else begin
			if (drop_upper)
				t_v <= '0;
			if (fill_top) begin
				t_v[t_ptr] <= 1'b1;
				t_ptr <= t_ptr + 1'b1;
			end
		end
		if (fill_top) begin
			t_tag[t_ptr] <= fill_addr[47:39];
			t_adr[t_ptr] <= fill_phys;
			{t_wr[t_ptr], t_us[t_ptr], t_nx[t_ptr]} <=
				{fill_wr, fill_us, fill_nx & nxe};
			{t_cd[t_ptr], t_wt[t_ptr]} <= {fill_cd, fill_wt};
		end
	end

endmodule // tlc_translation_caches

// >>> tlc_pkg.sv
// Package of constants and types for the translation lookaside caches.
// Assumes one core clock, an AHB-Lite register port and a page walker.
package tlc_pkg;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FLUSH = 8'h04;
	localparam logic [7:0] REG_INV_LO = 8'h08;
	localparam logic [7:0] REG_INV_HI = 8'h0C;
	localparam logic [7:0] REG_HITS = 8'h10;
	localparam logic [7:0] REG_MISSES = 8'h14;

	// Control fields and reset value.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_NXE_BIT = 2;
	localparam int CTRL_GPE_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h2;
	localparam int FLUSH_GO_BIT = 0;
	localparam int FLUSH_ALL_BIT = 1;

	// Address geometry.
	localparam int LIN_W = 48;
	localparam int FRAME_W = 40;
	localparam int VPN_W = 36;
	localparam int DIR_TAG_W = 27;
	localparam int TOP_TAG_W = 9;
	localparam int THIRD_TAG_W = 18;
	localparam int MTYPE_W = 3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	typedef enum logic [1:0] {
		TLC_MODE_32 = 2'd0,
		TLC_MODE_EXT = 2'd1,
		TLC_MODE_FOUR = 2'd2
	} tlc_mode_t;

	typedef enum logic [2:0] {
		TLC_LVL_NONE = 3'd0,
		TLC_LVL_TOP = 3'd1,
		TLC_LVL_THIRD = 3'd2,
		TLC_LVL_DIR = 3'd3,
		TLC_LVL_LEAF = 3'd4
	} tlc_level_t;

endpackage

// >>> tlc_walker_model.sv
// Page walker model that feeds finished levels into the caches.
// Assumes jobs from the bench arrive only while no fill is pending.
`timescale 1ns/1ps
module tlc_walker_model (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Job from the bench.
	input wire logic go,
	input wire logic slow,
	input wire logic [2:0] job_level,
	input wire logic [47:0] job_addr,
	input wire logic [39:0] job_phys,
	input wire logic [13:0] job_bits,
	// Accessed-bit request from the caches.
	input wire logic accessed_set_req,
	// Fill towards the caches.
	output logic fill_valid,
	output tlc_pkg::tlc_level_t fill_level,
	output logic [47:0] fill_addr,
	output logic [39:0] fill_phys,
	output logic [13:0] fill_bits
);
	import tlc_pkg::*;
	logic [104:0] job_q;
	logic [1:0] wait_cnt;
	logic [2:0] lvl_raw;
	// Sends a job, then resends it once its accessed bits are set.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fill_valid <= 1'b0;
			wait_cnt <= 2'd0;
			job_q <= '0;
		end else begin
			fill_valid <= go || wait_cnt == 2'd1;
			if (go) begin
				job_q <= {job_level, job_addr, job_phys, job_bits};
			end else if (wait_cnt == 2'd1) begin
				job_q[13] <= 1'b1;
			end
			if (accessed_set_req) begin
				wait_cnt <= slow ? 2'd3 : 2'd1;
			end else if (wait_cnt != 2'd0) begin
				wait_cnt <= wait_cnt - 2'd1;
			end
		end
	end
	// Idle lines show the inverse of the job so stale data never matches.
	assign {lvl_raw, fill_addr, fill_phys, fill_bits} =
		fill_valid ? job_q : ~job_q;
	assign fill_level = tlc_level_t'(lvl_raw);
endmodule // tlc_walker_model

// >>> tlc_chk.sv
// Checker for the translation lookaside caches.
// Assumes it is bound to the cache module and sees only its ports.
`timescale 1ns/1ps
module tlc_chk (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Bus answer.
	input wire logic hreadyout,
	input wire logic hresp,
	// Lookup.
	input wire logic lookup_valid,
	input wire logic lookup_done,
	input wire tlc_pkg::tlc_level_t lookup_level,
	input wire logic cache_disable_bit,
	input wire logic write_through_bit,
	input wire logic lookup_dirty,
	input wire logic [tlc_pkg::MTYPE_W-1:0] lookup_mtype,
	input wire logic lookup_global,
	// Fill and accessed-bit request.
	input wire logic fill_valid,
	input wire tlc_pkg::tlc_level_t fill_level,
	input wire logic fill_present,
	input wire logic fill_rsvd_clear,
	input wire logic fill_accessed,
	input wire logic accessed_set_req,
	input wire tlc_pkg::tlc_level_t accessed_set_level
);
	import tlc_pkg::*;
	// All checks share the core clock and its reset.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A valid leaf fill whose accessed bits are still clear.
	sequence s_ask;
		fill_valid && fill_level == TLC_LVL_LEAF && fill_present &&
			fill_rsvd_clear && !fill_accessed;
	endsequence
	// A fill with a missing entry or a set reserved bit.
	sequence s_bad;
		fill_valid && !(fill_present && fill_rsvd_clear);
	endsequence
	// Each property but p_bus ties an output to its cause.
	property p_done; lookup_done == $past(lookup_valid); endproperty
	a_done: assert property (p_done)
		else $error("lookup answer not one cycle after request");
	property p_hold; !lookup_valid |=> $stable(lookup_level); endproperty
	a_hold: assert property (p_hold)
		else $error("lookup level moved without a request");
	property p_attr;
		lookup_done && lookup_level != TLC_LVL_LEAF |->
			!lookup_dirty && lookup_mtype == 3'h0 && !lookup_global;
	endproperty
	a_attr: assert property (p_attr)
		else $error("leaf attributes on a non-leaf answer");
	property p_leaf;
		lookup_done && lookup_level == TLC_LVL_LEAF |->
			!cache_disable_bit && !write_through_bit;
	endproperty
	a_leaf: assert property (p_leaf)
		else $error("table bits on a leaf answer");
	property p_ask;
		s_ask |=> accessed_set_req && accessed_set_level == TLC_LVL_LEAF;
	endproperty
	a_ask: assert property (p_ask)
		else $error("accessed request missing");
	property p_bad; s_bad |=> !accessed_set_req; endproperty
	a_bad: assert property (p_bad)
		else $error("accessed request for an unusable entry");
	property p_cause; accessed_set_req |-> $past(fill_valid); endproperty
	a_cause: assert property (p_cause)
		else $error("accessed request without a fill");
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus)
		else $error("bus answer not ready and okay");
endmodule // tlc_chk

// >>> translation_lookaside_caches_tb_top.sv
// Bench for the translation lookaside caches with a walker model.
// Assumes the walker model and the checker are compiled before it.
`timescale 1ns/1ps
module translation_lookaside_caches_tb_top;
	import tlc_pkg::*;
	localparam logic [47:0] A = 48'h1234_5678_9000;
	localparam logic [47:0] T = 48'h8000_0000_0000;
	localparam logic [47:0] G = 48'h0000_0000_5000;
	localparam logic [39:0] P = 40'h12_3456_7890;
	logic ref_clk, rst_n, hsel, hwrite, lookup_valid, go, slow;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, job_level, lookup_mtype;
	logic [47:0] lookup_addr, job_addr, fill_addr;
	logic [39:0] job_phys, fill_phys, lookup_phys;
	logic [13:0] job_bits, fb;
	logic hreadyout, hresp, lookup_done, lookup_wr, lookup_us, nx, cd, wt;
	logic lookup_dirty, lookup_global, fill_valid, acc_req;
	tlc_level_t lookup_level, fill_level, acc_level;
	int fail_count, checks;
	tlc_translation_caches u_tlc_translation_caches (.ref_clk, .rst_n,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.lookup_valid, .lookup_addr, .lookup_done, .lookup_level,
		.lookup_phys, .lookup_wr, .lookup_us, .no_exec_bit(nx),
		.cache_disable_bit(cd), .write_through_bit(wt), .lookup_dirty,
		.lookup_mtype, .lookup_global, .fill_valid, .fill_level,
		.fill_addr, .fill_phys, .fill_wr(fb[0]), .fill_us(fb[1]),
		.fill_nx(fb[2]), .fill_cd(fb[3]), .fill_wt(fb[4]),
		.fill_present(fb[5]), .fill_rsvd_clear(fb[6]),
		.large_mapping_bit(fb[7]), .fill_dirty(fb[8]),
		.fill_global(fb[9]), .fill_mtype(fb[12:10]),
		.fill_accessed(fb[13]), .accessed_set_req(acc_req),
		.accessed_set_level(acc_level));
	tlc_walker_model u_tlc_walker_model (.ref_clk, .rst_n, .go, .slow,
		.job_level, .job_addr, .job_phys, .job_bits,
		.accessed_set_req(acc_req), .fill_valid, .fill_level,
		.fill_addr, .fill_phys, .fill_bits(fb));
	// Free-running core clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [63:0] s, e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Waits a bounded time for hready at a rising edge.
	task automatic hwait;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask
	// One single word transfer; read data lands in rd.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rd = hrdata;
	endtask
	// Looks up one address and compares the level and frame.
	task automatic look(input logic [47:0] a, input tlc_level_t l,
		input logic [39:0] p);
		lookup_valid <= 1'b1;
		lookup_addr <= a;
		@(posedge ref_clk);
		lookup_valid <= 1'b0;
		@(posedge ref_clk);
		chk("done", 64'(lookup_done), 64'h1);
		chk("level", 64'(lookup_level), 64'(l));
		if (l != TLC_LVL_NONE) chk("frame", 64'(lookup_phys), 64'(p));
	endtask
	// Hands one level to the walker and waits for its final fill.
	task automatic walk(input logic [2:0] l, input logic [47:0] a,
		input logic [39:0] p, input logic [13:0] b);
		int n;
		logic seen;
		go <= 1'b1;
		job_level <= l;
		job_addr <= a;
		job_phys <= p;
		job_bits <= b;
		@(posedge ref_clk);
		go <= 1'b0;
		n = 0;
		seen = 1'b0;
		// Ends on a fill that is final: accessed set, or never usable.
		do begin
			@(posedge ref_clk);
			n++;
			seen = fill_valid && (fb[13] || !(fb[5] && fb[6]));
		end while (!seen && n < 8);
		if (!seen) begin
			fail_count++;
			end_sim();
		end
		slow <= ~slow;
	endtask
	// Reset state, unmapped access and an empty cache.
	task automatic t_reset;
		ahb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", 64'(rd), 64'h2);
		ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 64'(rd), 64'h0);
		look(A, TLC_LVL_NONE, 40'h0);
		$display("reset test ended");
	endtask
	// Leaf fills after accessed-bit setting; rights and attributes.
	task automatic t_leaf;
		walk(TLC_LVL_LEAF, A, P, 14'h1767);
		look(A + 48'h123, TLC_LVL_LEAF, P);
		chk("nx", 64'(nx), 64'h0);
		chk("dirty", 64'(lookup_dirty), 64'h1);
		chk("mtype", 64'(lookup_mtype), 64'h5);
		chk("global", 64'(lookup_global), 64'h0);
		walk(TLC_LVL_LEAF, G, 40'h55, 14'h2C66);
		look(G, TLC_LVL_LEAF, 40'h55);
		chk("wr", 64'(lookup_wr), 64'h0);
		chk("us", 64'(lookup_us), 64'h1);
		chk("mtype", 64'(lookup_mtype), 64'h3);
		look(A + 48'h1000, TLC_LVL_NONE, 40'h0);
		ahb(1'b1, REG_CTRL, 32'h6);
		walk(TLC_LVL_LEAF, 48'h3000, P, 14'h2067);
		look(48'h3000, TLC_LVL_LEAF, P);
		chk("nx", 64'(nx), 64'h1);
		ahb(1'b0, REG_HITS, 32'h0);
		chk("hits", 64'(rd), 64'h3);
		ahb(1'b0, REG_MISSES, 32'h0);
		chk("misses", 64'(rd), 64'h2);
		ahb(1'b1, REG_CTRL, 32'h2);
		$display("leaf test ended");
	endtask
	// Unusable entries are never cached.
	task automatic t_refuse;
		logic [13:0] bad [4] = '{14'h3547, 14'h3527, 14'h1547, 14'h1527};
		foreach (bad[i]) begin
			walk(TLC_LVL_LEAF, 48'h7000, P, bad[i]);
			look(48'h7000, TLC_LVL_NONE, 40'h0);
		end
		walk(TLC_LVL_TOP, T, P, 14'h2019);
		look(T, TLC_LVL_NONE, 40'h0);
		$display("refuse test ended");
	endtask
	// Upper-level caches, their tags and search order.
	task automatic t_upper;
		walk(TLC_LVL_TOP, T, 40'h100, 14'h2079);
		look(T + 48'h4000_0000, TLC_LVL_TOP, 40'h100);
		chk("us", 64'(lookup_us), 64'h0);
		chk("cd", 64'(cd), 64'h1);
		chk("wt", 64'(wt), 64'h1);
		walk(TLC_LVL_THIRD, T, 40'h200, 14'h2073);
		look(T + 48'h20_0000, TLC_LVL_THIRD, 40'h200);
		chk("cd", 64'(cd), 64'h0);
		walk(TLC_LVL_DIR, T, 40'h300, 14'h20E3);
		look(T, TLC_LVL_THIRD, 40'h200);
		walk(TLC_LVL_DIR, T, 40'h300, 14'h2063);
		look(T + 48'h1000, TLC_LVL_DIR, 40'h300);
		look(T + 48'h20_0000, TLC_LVL_THIRD, 40'h200);
		ahb(1'b1, REG_CTRL, 32'h0);
		ahb(1'b1, REG_FLUSH, 32'h3);
		walk(TLC_LVL_DIR, 48'h40_0000, 40'h300, 14'h2063);
		look(48'h60_0000, TLC_LVL_DIR, 40'h300);
		ahb(1'b1, REG_CTRL, 32'h2);
		walk(TLC_LVL_LEAF, 48'h4060_0000, 40'hABC_DE00, 14'h35E7);
		look(48'h4065_3000, TLC_LVL_LEAF, 40'hABC_DE53);
		$display("upper test ended");
	endtask
	// Global marking, selective flush and page invalidate.
	task automatic t_flush;
		ahb(1'b1, REG_CTRL, 32'hA);
		walk(TLC_LVL_LEAF, G, P, 14'h3767);
		walk(TLC_LVL_LEAF, A, P, 14'h3567);
		walk(TLC_LVL_TOP, T, 40'h100, 14'h2079);
		look(G, TLC_LVL_LEAF, P);
		chk("global", 64'(lookup_global), 64'h1);
		ahb(1'b1, REG_FLUSH, 32'h1);
		look(A, TLC_LVL_NONE, 40'h0);
		look(T, TLC_LVL_NONE, 40'h0);
		look(G, TLC_LVL_LEAF, P);
		ahb(1'b1, REG_INV_LO, G[31:0]);
		ahb(1'b1, REG_INV_HI, {16'h0000, G[47:32]});
		look(G, TLC_LVL_NONE, 40'h0);
		walk(TLC_LVL_LEAF, G, P, 14'h3767);
		ahb(1'b1, REG_FLUSH, 32'h3);
		look(G, TLC_LVL_NONE, 40'h0);
		$display("flush test ended");
	endtask
	// Main sequence.
	initial begin
		{rst_n, hsel, hwrite, lookup_valid, go, slow} = '0;
		{haddr, hwdata, htrans, job_level, lookup_addr} = '0;
		{job_addr, job_phys, job_bits} = '0;
		hsize = 3'h2;
		fail_count = 0;
		checks = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_leaf();
		t_refuse();
		t_upper();
		t_flush();
		end_sim();
	end
endmodule // translation_lookaside_caches_tb_top
bind tlc_translation_caches tlc_chk u_tlc_chk (.ref_clk, .rst_n,
	.hreadyout, .hresp, .lookup_valid, .lookup_done, .lookup_level,
	.cache_disable_bit, .write_through_bit, .lookup_dirty,
	.lookup_mtype, .lookup_global, .fill_valid, .fill_level,
	.fill_present, .fill_rsvd_clear, .fill_accessed,
	.accessed_set_req, .accessed_set_level);
